// file: pfc_packet_format_config.sv
// module: packet format configuration registers and the framing settings they select
//
// Notes on behaviour
// RL1: sync field bit count from bits 7:2
// RL2: ten-bit preamble pair count across two registers
// RL3: length field one or two bytes
// RL4: address field included when bit set
// RL5: two-bit packet format select
// RL6: two-bit received data route select
// RL7: four-level symbol mapping swap bit
// RL8: transmission order select bit
// RL9: two-bit preamble pattern select
// RL10: header check type used in 4g format
// RL11: bit 4 fec kind or stop value
// RL12: bit 3 interleave or start value
// RL13: three-of-six coding enable
// RL14: manchester coding enable
// RL15: fixed or variable length mode
// RL16: crc codes none, 8 and 16 bit
// RL17: crc code 4 selects 24-bit crc
// RL18: crc code 5 selects 32-bit crc
// RL19: fixed length from two length registers
// RL20: reserved bits read zero, writes ignored
//
// Strobed register access is this design's own decision.
module pfc_packet_format_config (
  // clock and reset
  input  wire logic                        clock_i,
  input  wire logic                        rst_i,
  // register port
  input  wire logic [pfc_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [pfc_pkg::DATA_W-1:0]  wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [pfc_pkg::DATA_W-1:0]  rdata_o,
  // decoded framing settings
  output pfc_pkg::pfc_cfg_t                cfg_o,
  output logic                             cfg_fault_o
);

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [7:0] sync_field_bits_preamble_hi;
  logic [7:0] preamble_pair_count_lo;
  logic [7:0] length_width_address_ctrl;
  logic [7:0] format_rx_route_ctrl;
  logic [7:0] coding_length_mode_ctrl;
  logic [7:0] crc_select_ctrl;
  logic [7:0] fixed_length_hi;
  logic [7:0] fixed_length_lo;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire hit_sync  = (addr_i == pfc_pkg::SYNC_FIELD_BITS_PREAMBLE_HI_A);
  wire hit_prel  = (addr_i == pfc_pkg::PREAMBLE_PAIR_COUNT_LO_A);
  wire hit_lenw  = (addr_i == pfc_pkg::LENGTH_WIDTH_ADDR_A);
  wire hit_fmt   = (addr_i == pfc_pkg::FORMAT_RX_ROUTE_A);
  wire hit_code  = (addr_i == pfc_pkg::CODING_LENGTH_MODE_A);
  wire hit_crc   = (addr_i == pfc_pkg::CRC_SELECT_A);
  wire hit_flhi  = (addr_i == pfc_pkg::FIXED_LENGTH_HI_A);
  wire hit_fllo  = (addr_i == pfc_pkg::FIXED_LENGTH_LO_A);

  // RL20: reserved bits masked
  wire [7:0] wdata_lenw = wdata_i & pfc_pkg::LENGTH_WIDTH_ADDR_M;
  wire [7:0] wdata_code = wdata_i & pfc_pkg::CODING_LENGTH_MODE_M;

  // unmapped addresses read as zero
  wire [7:0] read_mux =
      hit_sync ? sync_field_bits_preamble_hi      :
      hit_prel ? preamble_pair_count_lo           :
      hit_lenw ? length_width_address_ctrl :
      hit_fmt  ? format_rx_route_ctrl      :
      hit_code ? coding_length_mode_ctrl   :
      hit_crc  ? crc_select_ctrl           :
      hit_flhi ? fixed_length_hi           :
      hit_fllo ? fixed_length_lo           : 8'h00;

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sync_field_bits_preamble_hi      <= pfc_pkg::SYNC_FIELD_BITS_PREAMBLE_HI_R;
      preamble_pair_count_lo           <= pfc_pkg::PREAMBLE_PAIR_COUNT_LO_R;
      length_width_address_ctrl <= pfc_pkg::LENGTH_WIDTH_ADDR_R;
      format_rx_route_ctrl      <= pfc_pkg::FORMAT_RX_ROUTE_R;
      coding_length_mode_ctrl   <= pfc_pkg::CODING_LENGTH_MODE_R;
      crc_select_ctrl           <= pfc_pkg::CRC_SELECT_R;
      fixed_length_hi           <= pfc_pkg::FIXED_LENGTH_HI_R;
      fixed_length_lo           <= pfc_pkg::FIXED_LENGTH_LO_R;
    end else if (wr_i) begin
      if (hit_sync) sync_field_bits_preamble_hi      <= wdata_i;
      if (hit_prel) preamble_pair_count_lo           <= wdata_i;
      if (hit_lenw) length_width_address_ctrl <= wdata_lenw;
      if (hit_fmt)  format_rx_route_ctrl      <= wdata_i;
      if (hit_code) coding_length_mode_ctrl   <= wdata_code;
      if (hit_crc)  crc_select_ctrl           <= wdata_i;
      if (hit_flhi) fixed_length_hi           <= wdata_i;
      if (hit_fllo) fixed_length_lo           <= wdata_i;
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= read_mux;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------
  pfc_pkg::pfc_format_t fmt;
  pfc_pkg::pfc_crc_t    crc_code;
  pfc_pkg::pfc_cfg_t    next_cfg;
  logic [31:0]          crc_poly_sel;
  logic [5:0]           crc_bits_sel;

  assign fmt      = pfc_pkg::pfc_format_t'(
                      format_rx_route_ctrl[pfc_pkg::FORMAT_HI:pfc_pkg::FORMAT_LO]);
  assign crc_code = pfc_pkg::pfc_crc_t'(crc_select_ctrl[pfc_pkg::CRC_HI:pfc_pkg::CRC_LO]);
  wire   is_4g    = (fmt == pfc_pkg::PFC_FMT_4G);
  wire   is_uart  = (fmt == pfc_pkg::PFC_FMT_UART);

  // RL16: generator and width per crc code
  always_comb begin
    case (crc_code)
      pfc_pkg::PFC_CRC_8: begin
        crc_poly_sel = pfc_pkg::POLY_8;
        crc_bits_sel = pfc_pkg::CRC_W_8;
      end
      pfc_pkg::PFC_CRC_16A: begin
        crc_poly_sel = pfc_pkg::POLY_16A;
        crc_bits_sel = pfc_pkg::CRC_W_16;
      end
      pfc_pkg::PFC_CRC_16B: begin
        crc_poly_sel = pfc_pkg::POLY_16B;
        crc_bits_sel = pfc_pkg::CRC_W_16;
      end
      // RL17: 24-bit generator
      pfc_pkg::PFC_CRC_24: begin
        crc_poly_sel = pfc_pkg::POLY_24;
        crc_bits_sel = pfc_pkg::CRC_W_24;
      end
      // RL18: 32-bit generator
      pfc_pkg::PFC_CRC_32: begin
        crc_poly_sel = pfc_pkg::POLY_32;
        crc_bits_sel = pfc_pkg::CRC_W_32;
      end
      // undefined codes fall back to no crc and raise the fault
      default: begin
        crc_poly_sel = 32'h00000000;
        crc_bits_sel = pfc_pkg::CRC_W_0;
      end
    endcase
  end

  always_comb begin
    next_cfg = '0;
    // RL1: sync field size
    next_cfg.sync_field_bits =
        sync_field_bits_preamble_hi[pfc_pkg::SYNC_BITS_HI:pfc_pkg::SYNC_BITS_LO];
    // RL2: preamble pair count
    next_cfg.preamble_pair_count =
        {sync_field_bits_preamble_hi[pfc_pkg::PREAMBLE_HI_HI:0], preamble_pair_count_lo};
    // RL3: length field width
    next_cfg.length_field_bytes =
        length_width_address_ctrl[pfc_pkg::LEN_WIDTH_BIT] ? pfc_pkg::LEN_BYTES_2
                                                          : pfc_pkg::LEN_BYTES_1;
    // RL4: address field inclusion
    next_cfg.addr_field_include  = length_width_address_ctrl[pfc_pkg::ADDR_INC_BIT];
    // RL5: packet format
    next_cfg.frame_format_select = fmt;
    // RL6: receive routing
    next_cfg.rx_route = pfc_pkg::pfc_route_t'(
        format_rx_route_ctrl[pfc_pkg::ROUTE_HI:pfc_pkg::ROUTE_LO]);
    // RL7: symbol mapping
    next_cfg.four_level_map_swap = format_rx_route_ctrl[pfc_pkg::MAP_SWAP_BIT];
    // RL8: transmission order
    next_cfg.order_swap          = format_rx_route_ctrl[pfc_pkg::ORDER_BIT];
    // RL9: preamble pattern
    next_cfg.preamble_pattern    = format_rx_route_ctrl[pfc_pkg::PATTERN_HI:0];
    // RL10: header check type only in 4g
    next_cfg.header_check_type   = is_4g & coding_length_mode_ctrl[pfc_pkg::HDR_CHECK_BIT];
    // RL11: shared bit 4 split by format
    next_cfg.fec_recursive       = is_4g & coding_length_mode_ctrl[pfc_pkg::FEC_STOP_BIT];
    next_cfg.uart_stop_value     = is_uart & coding_length_mode_ctrl[pfc_pkg::FEC_STOP_BIT];
    // RL12: shared bit 3 split by format
    next_cfg.interleave_on       = is_4g & coding_length_mode_ctrl[pfc_pkg::INTLV_START_BIT];
    next_cfg.uart_start_value    = is_uart & coding_length_mode_ctrl[pfc_pkg::INTLV_START_BIT];
    // RL13: three-of-six coding
    next_cfg.three_of_six_coding_on = coding_length_mode_ctrl[pfc_pkg::SIX_CODE_BIT];
    // RL14: manchester coding
    next_cfg.manchester_on       = coding_length_mode_ctrl[pfc_pkg::MANCH_BIT];
    // RL15: length mode
    next_cfg.length_mode_select  = coding_length_mode_ctrl[pfc_pkg::LEN_MODE_BIT];
    next_cfg.crc_mode            = crc_code;
    next_cfg.crc_bits            = crc_bits_sel;
    next_cfg.crc_poly            = crc_poly_sel;
    // RL19: fixed packet byte count
    next_cfg.fixed_length        = {fixed_length_hi, fixed_length_lo};
    next_cfg.crc_reg_aux         = crc_select_ctrl[pfc_pkg::CRC_AUX_HI:0];
  end

  // undefined route or crc code: settings are not usable as written
  wire next_fault = (next_cfg.rx_route == pfc_pkg::PFC_RX_UNDEF) |
                    (crc_code == pfc_pkg::PFC_CRC_R6) |
                    (crc_code == pfc_pkg::PFC_CRC_R7);

  // registered so the framer never sees a half-decoded setting
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cfg_o       <= '0;
      cfg_fault_o <= 1'b0;
    end else begin
      cfg_o       <= next_cfg;
      cfg_fault_o <= next_fault;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // RL1: sync field size
  sync_bits_map_a: assert property ( // RL1
    $past(wr_i) && $past(hit_sync) |=> cfg_o.sync_field_bits == $past(wdata_i[7:2], 2))
    else $error("sync field size not taken from written bits");

  // RL2: preamble low byte
  preamble_join_a: assert property ( // RL2
    wr_i && hit_prel ##1 !wr_i |=>
      cfg_o.preamble_pair_count[7:0] == $past(wdata_i, 2))
    else $error("preamble count low byte wrong");

  // RL3: length field width
  // the decode flop still shows zero one edge after reset leaves
  len_width_a: assert property ( // RL3
    !$past(rst_i) |->
      cfg_o.length_field_bytes == ($past(length_width_address_ctrl[7]) ? 2'h2 : 2'h1))
    else $error("length field width wrong");

  // RL4: address field inclusion
  addr_incl_a: assert property ( // RL4
    wr_i && hit_lenw |-> ##2 cfg_o.addr_field_include == $past(wdata_i[3], 2))
    else $error("address inclusion wrong");

  // RL5: packet format select
  format_sel_a: assert property ( // RL5
    wr_i && hit_fmt |-> ##2 cfg_o.frame_format_select == $past(wdata_i[7:6], 2))
    else $error("packet format wrong");

  // RL6: receive route
  route_map_a: assert property ( // RL6
    wr_i && hit_fmt ##1 !wr_i |=> cfg_o.rx_route == $past(wdata_i[5:4], 2))
    else $error("receive route not taken from written bits");

  // RL7: symbol mapping swap
  map_swap_a: assert property ( // RL7
    wr_i && hit_fmt |-> ##2 cfg_o.four_level_map_swap == $past(wdata_i[3], 2))
    else $error("symbol mapping wrong");

  // RL8: transmission order
  order_bit_a: assert property ( // RL8
    wr_i && hit_fmt |-> ##2 cfg_o.order_swap == $past(wdata_i[2], 2))
    else $error("transmission order wrong");

  // RL9: preamble pattern
  pattern_sel_a: assert property ( // RL9
    wr_i && hit_fmt |-> ##2 cfg_o.preamble_pattern == $past(wdata_i[1:0], 2))
    else $error("preamble pattern wrong");

  // RL10: header check gating
  hdr_check_gate_a: assert property ( // RL10
    cfg_o.header_check_type |-> cfg_o.frame_format_select == pfc_pkg::PFC_FMT_4G)
    else $error("header check type outside 4g format");

  // RL11: shared bit four
  shared_bit_a: assert property ( // RL11
    !(cfg_o.fec_recursive && cfg_o.uart_stop_value))
    else $error("bit 4 used in two meanings at once");

  // RL12: interleave in 4g only
  interleave_a: assert property ( // RL12
    wr_i && hit_code |-> ##2 cfg_o.interleave_on ==
      ($past(wdata_i[3], 2) && cfg_o.frame_format_select == pfc_pkg::PFC_FMT_4G))
    else $error("interleave enable wrong");

  // RL13: three-of-six coding
  six_code_a: assert property ( // RL13
    wr_i && hit_code |-> ##2 cfg_o.three_of_six_coding_on == $past(wdata_i[2], 2))
    else $error("three-of-six enable wrong");

  // RL14: manchester coding
  manch_code_a: assert property ( // RL14
    wr_i && hit_code |-> ##2 cfg_o.manchester_on == $past(wdata_i[1], 2))
    else $error("manchester enable wrong");

  // RL15: length mode
  len_mode_a: assert property ( // RL15
    wr_i && hit_code |-> ##2 cfg_o.length_mode_select == $past(wdata_i[0], 2))
    else $error("length mode wrong");

  // RL16: first 16-bit generator
  crc16_poly_a: assert property ( // RL16
    cfg_o.crc_mode == pfc_pkg::PFC_CRC_16A |->
      cfg_o.crc_poly == 32'h00008005 && cfg_o.crc_bits == 6'h10)
    else $error("16-bit crc generator wrong");

  // RL17: 24-bit generator
  crc24_poly_a: assert property ( // RL17
    cfg_o.crc_mode == pfc_pkg::PFC_CRC_24 |->
      cfg_o.crc_poly == 32'h00864CBF && cfg_o.crc_bits == 6'h18)
    else $error("24-bit crc generator wrong");

  // RL18: 32-bit generator
  crc32_poly_a: assert property ( // RL18
    cfg_o.crc_mode == pfc_pkg::PFC_CRC_32 |->
      cfg_o.crc_poly == 32'h4C011BB7 && cfg_o.crc_bits == 6'h20)
    else $error("32-bit crc generator wrong");

  // RL16: no crc on code zero
  crc_none_a: assert property ( // RL16
    cfg_o.crc_mode == pfc_pkg::PFC_CRC_NONE |-> cfg_o.crc_bits == 6'h00)
    else $error("crc appended with code zero");

  // RL19: fixed length high byte
  fixed_len_hi_a: assert property ( // RL19
    wr_i && hit_flhi |-> ##2 cfg_o.fixed_length[15:8] == $past(wdata_i, 2))
    else $error("fixed length high byte wrong");

  // RL19: fixed length low byte
  fixed_len_a: assert property ( // RL19
    wr_i && hit_fllo ##1 !wr_i |=> cfg_o.fixed_length[7:0] == $past(wdata_i, 2))
    else $error("fixed length low byte wrong");

  // RL20: reserved bits read zero
  reserved_zero_a: assert property ( // RL20
    rd_i && (hit_lenw || hit_code) |=> (rdata_o & 8'h77 & {8{$past(hit_lenw)}}) == 8'h00 &&
      (rdata_o & 8'hC0 & {8{$past(hit_code)}}) == 8'h00)
    else $error("reserved bits read nonzero");

  // read data only in its answer cycle
  read_window_a: assert property (
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data outside its cycle");

  // fault flag tracks the settings it guards
  // both come from the same edge, so they never disagree
  fault_flag_a: assert property (
    cfg_fault_o == (cfg_o.rx_route == pfc_pkg::PFC_RX_UNDEF ||
                    cfg_o.crc_mode >= pfc_pkg::PFC_CRC_R6))
    else $error("configuration fault flag wrong");

  // ------------------------------------------------------------
  // coverage
  // ------------------------------------------------------------
  cov_4g_fec_c:   cover property (cfg_o.frame_format_select == pfc_pkg::PFC_FMT_4G &&
                                  cfg_o.fec_recursive && cfg_o.interleave_on);
  cov_uart_c:     cover property (cfg_o.uart_start_value ##1 cfg_o.uart_stop_value);
  cov_crc32_c:    cover property (cfg_o.crc_mode == pfc_pkg::PFC_CRC_32);
  cov_wr_rd_c:    cover property (wr_i && hit_sync ##1 rd_i && hit_sync);
  cov_fault_c:    cover property (cfg_fault_o);

endmodule

// file: pfc_pkg.sv
// package: register map, field layout and encodings of the packet format configuration
package pfc_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int          ADDR_W                 = 8;
  localparam int          DATA_W                 = 8;
  localparam logic [7:0]  SYNC_FIELD_BITS_PREAMBLE_HI_A = 8'h2B;
  localparam logic [7:0]  PREAMBLE_PAIR_COUNT_LO_A      = 8'h2C;
  localparam logic [7:0]  LENGTH_WIDTH_ADDR_A    = 8'h2D;
  localparam logic [7:0]  FORMAT_RX_ROUTE_A      = 8'h2E;
  localparam logic [7:0]  CODING_LENGTH_MODE_A   = 8'h2F;
  localparam logic [7:0]  CRC_SELECT_A           = 8'h30;
  localparam logic [7:0]  FIXED_LENGTH_HI_A      = 8'h31;
  localparam logic [7:0]  FIXED_LENGTH_LO_A      = 8'h32;

  // ------------------------------------------------------------
  // reset values and writable masks
  // ------------------------------------------------------------
  localparam logic [7:0]  SYNC_FIELD_BITS_PREAMBLE_HI_R = 8'h80;
  localparam logic [7:0]  PREAMBLE_PAIR_COUNT_LO_R      = 8'h10;
  localparam logic [7:0]  LENGTH_WIDTH_ADDR_R    = 8'h00;
  localparam logic [7:0]  FORMAT_RX_ROUTE_R      = 8'h20;
  localparam logic [7:0]  CODING_LENGTH_MODE_R   = 8'h00;
  localparam logic [7:0]  CRC_SELECT_R           = 8'h2C;
  localparam logic [7:0]  FIXED_LENGTH_HI_R      = 8'h00;
  localparam logic [7:0]  FIXED_LENGTH_LO_R      = 8'h14;
  localparam logic [7:0]  LENGTH_WIDTH_ADDR_M    = 8'h88;
  localparam logic [7:0]  CODING_LENGTH_MODE_M   = 8'h3F;
  localparam logic [7:0]  FULL_M                 = 8'hFF;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int SYNC_BITS_HI   = 7;
  localparam int SYNC_BITS_LO   = 2;
  localparam int PREAMBLE_HI_HI = 1;
  localparam int LEN_WIDTH_BIT  = 7;
  localparam int ADDR_INC_BIT   = 3;
  localparam int FORMAT_HI      = 7;
  localparam int FORMAT_LO      = 6;
  localparam int ROUTE_HI       = 5;
  localparam int ROUTE_LO       = 4;
  localparam int MAP_SWAP_BIT   = 3;
  localparam int ORDER_BIT      = 2;
  localparam int PATTERN_HI     = 1;
  localparam int HDR_CHECK_BIT  = 5;
  localparam int FEC_STOP_BIT   = 4;
  localparam int INTLV_START_BIT = 3;
  localparam int SIX_CODE_BIT   = 2;
  localparam int MANCH_BIT      = 1;
  localparam int LEN_MODE_BIT   = 0;
  localparam int CRC_HI         = 7;
  localparam int CRC_LO         = 5;
  localparam int CRC_AUX_HI     = 4;

  // ------------------------------------------------------------
  // crc generators and widths
  // ------------------------------------------------------------
  localparam logic [31:0] POLY_8     = 32'h00000007;
  localparam logic [31:0] POLY_16A   = 32'h00008005;
  localparam logic [31:0] POLY_16B   = 32'h00001021;
  localparam logic [31:0] POLY_24    = 32'h00864CBF;
  localparam logic [31:0] POLY_32    = 32'h4C011BB7;
  localparam logic [5:0]  CRC_W_0    = 6'h00;
  localparam logic [5:0]  CRC_W_8    = 6'h08;
  localparam logic [5:0]  CRC_W_16   = 6'h10;
  localparam logic [5:0]  CRC_W_24   = 6'h18;
  localparam logic [5:0]  CRC_W_32   = 6'h20;
  localparam logic [1:0]  LEN_BYTES_1 = 2'h1;
  localparam logic [1:0]  LEN_BYTES_2 = 2'h2;

  // ------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PFC_FMT_BASIC = 2'b00,
    PFC_FMT_4G    = 2'b01,
    PFC_FMT_UART  = 2'b10,
    PFC_FMT_STACK = 2'b11
  } pfc_format_t;

  typedef enum logic [1:0] {
    PFC_RX_NORMAL = 2'b00,
    PFC_RX_FIFO   = 2'b01,
    PFC_RX_PIN    = 2'b10,
    PFC_RX_UNDEF  = 2'b11
  } pfc_route_t;

  typedef enum logic [2:0] {
    PFC_CRC_NONE = 3'b000,
    PFC_CRC_8    = 3'b001,
    PFC_CRC_16A  = 3'b010,
    PFC_CRC_16B  = 3'b011,
    PFC_CRC_24   = 3'b100,
    PFC_CRC_32   = 3'b101,
    PFC_CRC_R6   = 3'b110,
    PFC_CRC_R7   = 3'b111
  } pfc_crc_t;

  typedef struct packed {
    logic [5:0]  sync_field_bits;
    logic [9:0]  preamble_pair_count;
    logic [1:0]  length_field_bytes;
    logic        addr_field_include;
    pfc_format_t frame_format_select;
    pfc_route_t  rx_route;
    logic        four_level_map_swap;
    logic        order_swap;
    logic [1:0]  preamble_pattern;
    logic        header_check_type;
    logic        fec_recursive;
    logic        interleave_on;
    logic        uart_stop_value;
    logic        uart_start_value;
    logic        three_of_six_coding_on;
    logic        manchester_on;
    logic        length_mode_select;
    pfc_crc_t    crc_mode;
    logic [5:0]  crc_bits;
    logic [31:0] crc_poly;
    logic [15:0] fixed_length;
    logic [4:0]  crc_reg_aux;
  } pfc_cfg_t;

endpackage

// file: pfc_packet_format_config_tb.sv
// testbench: packet format configuration registers against a bench register model
module pfc_packet_format_config_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // design hookup
  // ------------------------------------------------------------
  logic                       clock_i = 1'b0;
  logic                       rst_i   = 1'b1;
  logic [7:0]                 addr_i  = 8'h00;
  logic [7:0]                 wdata_i = 8'h00;
  logic                       wr_i    = 1'b0;
  logic                       rd_i    = 1'b0;
  logic [7:0]                 rdata_o;
  pfc_pkg::pfc_cfg_t          cfg_o;
  logic                       cfg_fault_o;
  int                         miscompares     = 0;
  int                         samples_checked = 0;
  int                         cycles          = 0;

  always #5 clock_i = ~clock_i;

  pfc_packet_format_config DUT (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .addr_i      (addr_i),
    .wdata_i     (wdata_i),
    .wr_i        (wr_i),
    .rd_i        (rd_i),
    .rdata_o     (rdata_o),
    .cfg_o       (cfg_o),
    .cfg_fault_o (cfg_fault_o)
  );

  // ------------------------------------------------------------
  // register model
  // ------------------------------------------------------------
  logic [7:0] rst_v [0:7] = '{8'h80, 8'h10, 8'h00, 8'h20, 8'h00, 8'h2C, 8'h00, 8'h14};
  logic [7:0] msk_v [0:7] = '{8'hFF, 8'hFF, 8'h88, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0] m     [0:7] = '{8'h80, 8'h10, 8'h00, 8'h20, 8'h00, 8'h2C, 8'h00, 8'h14};
  logic [7:0] m_d   [0:7] = '{8'h80, 8'h10, 8'h00, 8'h20, 8'h00, 8'h2C, 8'h00, 8'h14};
  logic       armed = 1'b0;
  logic       rd_d  = 1'b0;
  logic       rst_d = 1'b1;
  logic [7:0] exp_d = 8'h00;

  function automatic logic mapped(input logic [7:0] a);
    return (a >= 8'h2B) && (a <= 8'h32);
  endfunction

  function automatic pfc_pkg::pfc_cfg_t dec(input logic [7:0] r [0:7]);
    pfc_pkg::pfc_cfg_t c;
    logic              f4g;
    logic              fu;
    c = '0;
    f4g = (r[3][7:6] == 2'h1);
    fu  = (r[3][7:6] == 2'h2);
    c.sync_field_bits        = r[0][7:2];
    c.preamble_pair_count    = {r[0][1:0], r[1]};
    c.length_field_bytes     = r[2][7] ? 2'h2 : 2'h1;
    c.addr_field_include     = r[2][3];
    c.frame_format_select    = pfc_pkg::pfc_format_t'(r[3][7:6]);
    c.rx_route               = pfc_pkg::pfc_route_t'(r[3][5:4]);
    c.four_level_map_swap    = r[3][3];
    c.order_swap             = r[3][2];
    c.preamble_pattern       = r[3][1:0];
    c.header_check_type      = f4g & r[4][5];
    c.fec_recursive          = f4g & r[4][4];
    c.interleave_on          = f4g & r[4][3];
    c.uart_stop_value        = fu & r[4][4];
    c.uart_start_value       = fu & r[4][3];
    c.three_of_six_coding_on = r[4][2];
    c.manchester_on          = r[4][1];
    c.length_mode_select     = r[4][0];
    c.crc_mode               = pfc_pkg::pfc_crc_t'(r[5][7:5]);
    case (r[5][7:5])
      3'h1: begin c.crc_bits = 6'h08; c.crc_poly = 32'h00000007; end
      3'h2: begin c.crc_bits = 6'h10; c.crc_poly = 32'h00008005; end
      3'h3: begin c.crc_bits = 6'h10; c.crc_poly = 32'h00001021; end
      3'h4: begin c.crc_bits = 6'h18; c.crc_poly = 32'h00864CBF; end
      3'h5: begin c.crc_bits = 6'h20; c.crc_poly = 32'h4C011BB7; end
      default: begin c.crc_bits = 6'h00; c.crc_poly = 32'h00000000; end
    endcase
    c.fixed_length = {r[6], r[7]};
    c.crc_reg_aux  = r[5][4:0];
    return c;
  endfunction

  // ------------------------------------------------------------
  // compare tasks
  // ------------------------------------------------------------
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t rdata got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_cfg(input pfc_pkg::pfc_cfg_t got, input pfc_pkg::pfc_cfg_t exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t cfg got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t fault got %h exp %h", $time, got, exp);
    end
  endtask

  // ------------------------------------------------------------
  // monitor: old values at each edge are the previous cycle's outputs
  // ------------------------------------------------------------
  always @(posedge clock_i) begin
    if (armed) begin
      cmp8(rdata_o, (rd_d && !rst_d) ? exp_d : 8'h00);
      cmp_cfg(cfg_o, rst_d ? pfc_pkg::pfc_cfg_t'('0) : dec(m_d));
      cmp1(cfg_fault_o, !rst_d && ((m_d[3][5:4] == 2'h3) || (m_d[5][7:6] == 2'h3)));
    end
    armed = 1'b1;
    rd_d  = rd_i;
    rst_d = rst_i;
    exp_d = mapped(addr_i) ? m[addr_i - 8'h2B] : 8'h00;
    m_d   = m;
    if (rst_i)
      m = rst_v;
    else if (wr_i && mapped(addr_i))
      m[addr_i - 8'h2B] = wdata_i & msk_v[addr_i - 8'h2B];
  end

  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  // one bus cycle; called at a rising edge, returns at the next one
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    wr_i    <= w;
    rd_i    <= r;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clock_i);
  endtask

  task automatic read_all();
    for (int i = 0; i < 10; i++)
      bus(1'b0, 1'b1, 8'h2A + i[7:0], 8'h00);
    repeat (3) bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask

  task automatic test_end(input string name);
    $display("test %s done, %0d checks, %0d mismatches", name, samples_checked, miscompares);
  endtask

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // long stalls are a hang, not a slow test
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    logic [7:0] a;
    void'($urandom(32'hEAF979E7));
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    read_all();
    test_end("reset_values");
    // reserved bits stay zero, unmapped neighbours ignore writes
    for (int i = 0; i < 10; i++)
      bus(1'b1, 1'b0, 8'h2A + i[7:0], 8'hFF);
    read_all();
    for (int i = 0; i < 10; i++)
      bus(1'b1, 1'b0, 8'h2A + i[7:0], 8'h00);
    read_all();
    test_end("reserved_and_unmapped");
    // every format against every route, coding bits 5:3 set for route zero, bits 5 and 2:0 for the others
    for (int f = 0; f < 4; f++) begin
      for (int r = 0; r < 4; r++) begin
        bus(1'b1, 1'b0, 8'h2E, {f[1:0], r[1:0], 4'h5 + r[3:0]});
        bus(1'b1, 1'b0, 8'h2F, (r == 0) ? 8'h38 : 8'h27);
        bus(1'b0, 1'b1, 8'h2E, 8'h00);
      end
    end
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 1'b0, 8'h30, {c[2:0], 5'h15});
      bus(1'b0, 1'b1, 8'h30, 8'h00);
    end
    bus(1'b1, 1'b0, 8'h2D, 8'h80);
    bus(1'b1, 1'b0, 8'h2D, 8'h08);
    bus(1'b1, 1'b0, 8'h31, 8'hAB);
    bus(1'b1, 1'b0, 8'h32, 8'hCD);
    read_all();
    test_end("field_codes");
    // random traffic over the map and its edges
    for (int i = 0; i < 400; i++) begin
      a = 8'h29 + 8'($urandom % 12);
      case ($urandom % 3)
        0: bus(1'b1, 1'b0, a, 8'($urandom));
        1: bus(1'b0, 1'b1, a, 8'($urandom));
        default: bus(1'b0, 1'b0, a, 8'($urandom));
      endcase
    end
    read_all();
    test_end("random_traffic");
    // reset in mid-run restores every register
    rst_i <= 1'b1;
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    rst_i <= 1'b0;
    read_all();
    test_end("second_reset");
    complete_run();
  end
endmodule
